// >>> pwm_gen_a_value_load_enable.sv
// Purpose: buffered pulse widths for channels 4/5 and generator A enable/control
// Assumes: counter, modulus, reload event and mode come from the rest of the module
// Notes:   wishbone ack one cycle after request, dropped the next cycle
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// R01: pulse-width registers hold 16-bit signed widths in pwm clock periods.
// R02: width zero or negative keeps the output low all period.
// R03: width at or above modulus keeps the output high all period.
// R04: activated output is high, deactivated output is low.
// R05: written width waits in buffer until load-okay and next reload.
// R06: reads return the buffered width, not the one in use.
// R07: mode off: enable bit drives generators A,B,C and outputs 0-5.
// R08: mode on: enable bit drives only generator A and outputs 0,1.
// R09: mode off: load-okay A loads prescaler, modulus and all six widths.
// R10: mode on: load-okay A loads prescaler, modulus and widths 0,1 only.
// R11: load-okay sets only by writing one after reading it zero.
// R12: load-okay clears after load, or by writing zero before reload.
// R13: reset clears load-okay so nothing is pending.
// R14: software sets load-okay before enable, never clears it with enable.
// R15: bit 0 gates the reload flag onto the interrupt request.
// R16: reload flag sets every reload; cleared by read-set then write one.
// R17: interrupt request is high exactly when flag and enable are set; the code registers it, so it follows them one cycle later.
module pwm_gen_a_value_load_enable #(
	parameter int PW_W  = pwm_a_pkg::PW_W,
	parameter int CNT_W = pwm_a_pkg::CNT_W
) (
	input  wire logic             sys_clk_i,
	input  wire logic             reset_i,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [31:0]      wb_adr_i,
	input  wire logic [31:0]      wb_dat_i,
	input  wire logic [3:0]       wb_sel_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	input  wire logic             multi_generator_mode_i,
	input  wire logic             reload_a_i,
	input  wire logic             reload_c_i,
	input  wire logic             load_okay_c_i,
	input  wire logic             gen_c_enable_i,
	input  wire logic [5:4]       output_software_control_i,
	input  wire logic [5:4]       output_software_value_i,
	input  wire logic [CNT_W-1:0] counter_modulus_c_i,
	input  wire logic [CNT_W-1:0] count_c_i,
	output logic                  gen_a_enable_o,
	output logic                  gen_bc_enable_o,
	output logic                  load_a_o,
	output logic                  load_okay_a_o,
	output logic                  reload_irq_a_o,
	output logic [PW_W-1:0]       pulse_width_ch4_o,
	output logic [PW_W-1:0]       pulse_width_ch5_o,
	output logic                  pwm4_o,
	output logic                  pwm5_o
);
	logic [PW_W-1:0] pulse_width_ch4;
	logic [PW_W-1:0] pulse_width_ch5;
	logic            gen_a_enable_bit;
	logic            load_okay_a;
	logic            reload_irq_enable_a;
	logic            reload_flag_a;
	logic            load_okay_armed;
	logic            rflag_armed;
	logic            ch_enable;
	logic            ch_load;
	logic            bus_req;
	logic            wr_now;
	logic            rd_now;
	logic [3:0]      reg_adr;
	logic [31:0]     next_rdata;

	function automatic logic [15:0] merge16(input logic [15:0] old_v,
		input logic [31:0] d, input logic [3:0] sel);
		logic [15:0] r;
		r = old_v;
		if (sel[0])
			r[7:0] = d[7:0];
		if (sel[1])
			r[15:8] = d[15:8];
		return r;
	endfunction : merge16

	assign bus_req = wb_cyc_i && wb_stb_i;
	assign reg_adr = wb_adr_i[pwm_a_pkg::AW-1:0];
	assign wr_now  = bus_req && wb_ack_o && wb_we_i;
	assign rd_now  = bus_req && wb_ack_o && !wb_we_i;

	// mode off: one enable drives all three generators and outputs 0-5
	assign ch_enable = multi_generator_mode_i ? gen_c_enable_i
		: gen_a_enable_bit; // [R07] [R08]
	// channels 4/5 follow generator A load only while mode is off
	assign ch_load = multi_generator_mode_i ? (reload_c_i && load_okay_c_i)
		: (reload_a_i && load_okay_a); // [R09] [R10]

	always_comb
	begin
		next_rdata = 32'h0000_0000;
		unique case (reg_adr)
			pwm_a_pkg::OFF_PW4: next_rdata[PW_W-1:0] = pulse_width_ch4; // [R06]
			pwm_a_pkg::OFF_PW5: next_rdata[PW_W-1:0] = pulse_width_ch5; // [R06]
			pwm_a_pkg::OFF_ENC:
			begin
				next_rdata[pwm_a_pkg::BIT_EN]   = gen_a_enable_bit;
				next_rdata[pwm_a_pkg::BIT_LOAD_OKAY] = load_okay_a;
				next_rdata[pwm_a_pkg::BIT_RIE]  = reload_irq_enable_a;
			end
			pwm_a_pkg::OFF_RLD: next_rdata[pwm_a_pkg::BIT_RFLAG] = reload_flag_a;
			default: next_rdata = 32'h0000_0000;
		endcase
	end

	// registered ack: one wait state, dropped the cycle after
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req && !wb_ack_o;
			if (bus_req && !wb_ack_o && !wb_we_i)
				wb_dat_o <= next_rdata;
		end
	end

	// buffered widths; generator copies come from ch_load only [R01] [R05]
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pulse_width_ch4 <= pwm_a_pkg::PW_RESET;
			pulse_width_ch5 <= pwm_a_pkg::PW_RESET;
		end
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_PW4)
			pulse_width_ch4 <= merge16(pulse_width_ch4, wb_dat_i, wb_sel_i);
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_PW5)
			pulse_width_ch5 <= merge16(pulse_width_ch5, wb_dat_i, wb_sel_i);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			pulse_width_ch4_o <= pwm_a_pkg::PW_RESET;
			pulse_width_ch5_o <= pwm_a_pkg::PW_RESET;
		end
		else if (ch_load)
		begin
			pulse_width_ch4_o <= pulse_width_ch4; // [R05]
			pulse_width_ch5_o <= pulse_width_ch5;
		end
	end

	// enable and interrupt enable bits; software is trusted on write order [R14]
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			gen_a_enable_bit    <= pwm_a_pkg::ENC_RESET[pwm_a_pkg::BIT_EN];
			reload_irq_enable_a <= pwm_a_pkg::ENC_RESET[pwm_a_pkg::BIT_RIE];
		end
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_ENC && wb_sel_i[0])
		begin
			gen_a_enable_bit    <= wb_dat_i[pwm_a_pkg::BIT_EN];
			reload_irq_enable_a <= wb_dat_i[pwm_a_pkg::BIT_RIE];
		end
	end

	// read-zero arms the set; any later write to the register disarms
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			load_okay_armed <= 1'b0;
		else if (rd_now && reg_adr == pwm_a_pkg::OFF_ENC)
			load_okay_armed <= !load_okay_a; // [R11]
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_ENC)
			load_okay_armed <= 1'b0;
	end

	// a set in the reload cycle wins, so a fresh request is not lost
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			load_okay_a <= 1'b0; // [R13]
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_ENC && wb_sel_i[0]
			&& wb_dat_i[pwm_a_pkg::BIT_LOAD_OKAY] && load_okay_armed)
			load_okay_a <= 1'b1; // [R11]
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_ENC && wb_sel_i[0]
			&& !wb_dat_i[pwm_a_pkg::BIT_LOAD_OKAY])
			load_okay_a <= 1'b0; // [R12]
		else if (reload_a_i)
			load_okay_a <= 1'b0; // [R12]
	end

	// a reload between the read and the write cancels the clear
	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			rflag_armed <= 1'b0;
		else if (reload_a_i)
			rflag_armed <= 1'b0; // [R16]
		else if (rd_now && reg_adr == pwm_a_pkg::OFF_RLD)
			rflag_armed <= reload_flag_a;
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_RLD)
			rflag_armed <= 1'b0;
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			reload_flag_a <= 1'b0;
		else if (reload_a_i)
			reload_flag_a <= 1'b1; // [R16]
		else if (wr_now && reg_adr == pwm_a_pkg::OFF_RLD && wb_sel_i[0]
			&& wb_dat_i[pwm_a_pkg::BIT_RFLAG] && rflag_armed)
			reload_flag_a <= 1'b0; // [R16]
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
		begin
			gen_a_enable_o  <= 1'b0;
			gen_bc_enable_o <= 1'b0;
			load_a_o        <= 1'b0;
			load_okay_a_o   <= 1'b0;
			reload_irq_a_o  <= 1'b0;
		end
		else
		begin
			gen_a_enable_o  <= gen_a_enable_bit; // [R07] [R08]
			gen_bc_enable_o <= gen_a_enable_bit && !multi_generator_mode_i; // [R07]
			// prescaler and modulus A load with it, in either mode
			load_a_o        <= reload_a_i && load_okay_a; // [R09] [R10]
			load_okay_a_o   <= load_okay_a;
			reload_irq_a_o  <= reload_flag_a && reload_irq_enable_a; // [R15] [R17]
		end
	end

	pwm_channel_out #(
		.PW_W  (PW_W),
		.CNT_W (CNT_W)
	) u_ch4 (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.enable_i  (ch_enable),
		.sw_ctl_i  (output_software_control_i[4]),
		.sw_val_i  (output_software_value_i[4]),
		.value_i   (pulse_width_ch4_o),
		.modulus_i (counter_modulus_c_i),
		.count_i   (count_c_i),
		.pin_o     (pwm4_o)
	);

	pwm_channel_out #(
		.PW_W  (PW_W),
		.CNT_W (CNT_W)
	) u_ch5 (
		.sys_clk_i (sys_clk_i),
		.reset_i   (reset_i),
		.enable_i  (ch_enable),
		.sw_ctl_i  (output_software_control_i[5]),
		.sw_val_i  (output_software_value_i[5]),
		.value_i   (pulse_width_ch5_o),
		.modulus_i (counter_modulus_c_i),
		.count_i   (count_c_i),
		.pin_o     (pwm5_o)
	);

	// checks
	property p_load_a;
		@(posedge sys_clk_i) disable iff (reset_i)
		reload_a_i && load_okay_a |=> load_a_o;
	endproperty
	a_load_a: assert property (p_load_a) // [R09] [R10]
		else $error("prescaler and modulus load missed at reload");
	property p_load_okay_set_only_armed;
		@(posedge sys_clk_i) disable iff (reset_i)
		$rose(load_okay_a) |-> $past(load_okay_armed) && $past(wr_now);
	endproperty
	a_load_okay_set_only_armed: assert property (p_load_okay_set_only_armed) // [R11]
		else $error("load-okay set without read-zero arm");
	property p_load_okay_clear_on_reload;
		@(posedge sys_clk_i) disable iff (reset_i)
		reload_a_i && load_okay_a && !wr_now |=> !load_okay_a;
	endproperty
	a_load_okay_clear_on_reload: assert property (p_load_okay_clear_on_reload) // [R12]
		else $error("load-okay not cleared by reload");
	property p_rflag_set;
		@(posedge sys_clk_i) disable iff (reset_i)
		reload_a_i |=> reload_flag_a;
	endproperty
	a_rflag_set: assert property (p_rflag_set) // [R16]
		else $error("reload flag not set");
	property p_irq;
		@(posedge sys_clk_i) disable iff (reset_i)
		##1 1'b1 |-> reload_irq_a_o == $past(reload_flag_a && reload_irq_enable_a);
	endproperty
	a_irq: assert property (p_irq) // [R15] [R17]
		else $error("interrupt request does not follow flag and enable");
	property p_load_ch4;
		@(posedge sys_clk_i) disable iff (reset_i)
		ch_load |=> pulse_width_ch4_o == $past(pulse_width_ch4);
	endproperty
	a_load_ch4: assert property (p_load_ch4) // [R05]
		else $error("channel 4 width not loaded at reload");
	property p_hold_ch4;
		@(posedge sys_clk_i) disable iff (reset_i)
		!ch_load |=> $stable(pulse_width_ch4_o);
	endproperty
	a_hold_ch4: assert property (p_hold_ch4) // [R05]
		else $error("channel 4 width changed without load");
	property p_neg_low;
		@(posedge sys_clk_i) disable iff (reset_i)
		ch_enable && !output_software_control_i[4] && $signed(pulse_width_ch4_o) <= 0
			|=> !pwm4_o;
	endproperty
	a_neg_low: assert property (p_neg_low) // [R02] [R04]
		else $error("non-positive width drove output high");
	property p_full_high;
		@(posedge sys_clk_i) disable iff (reset_i)
		ch_enable && !output_software_control_i[5] && !pulse_width_ch5_o[PW_W-1]
			&& pulse_width_ch5_o != 0
			&& pulse_width_ch5_o >= {1'b0, counter_modulus_c_i} |=> pwm5_o;
	endproperty
	a_full_high: assert property (p_full_high) // [R03] [R04]
		else $error("width at modulus did not hold output high");
	property p_bc_enable;
		@(posedge sys_clk_i) disable iff (reset_i)
		multi_generator_mode_i ##1 multi_generator_mode_i |-> !gen_bc_enable_o;
	endproperty
	a_bc_enable: assert property (p_bc_enable) // [R08]
		else $error("generators B/C enabled in multi-generator mode");
	property p_read_buffer;
		@(posedge sys_clk_i) disable iff (reset_i)
		bus_req && !wb_ack_o && !wb_we_i && reg_adr == pwm_a_pkg::OFF_PW4
			|=> wb_dat_o[PW_W-1:0] == $past(pulse_width_ch4);
	endproperty
	a_read_buffer: assert property (p_read_buffer) // [R06]
		else $error("read did not return buffered width");
endmodule : pwm_gen_a_value_load_enable
`default_nettype wire

// >>> pwm_a_pkg.sv
// Purpose: shared constants for the generator A value/load/enable block
// Assumes: 32-bit classic Wishbone, word-aligned registers
// Notes:   offsets are byte addresses
package pwm_a_pkg;
	localparam int          AW           = 4;
	localparam logic [3:0]  OFF_PW4      = 4'h0;
	localparam logic [3:0]  OFF_PW5      = 4'h4;
	localparam logic [3:0]  OFF_ENC      = 4'h8;
	localparam logic [3:0]  OFF_RLD      = 4'hc;
	localparam int          BIT_EN       = 7;
	localparam int          BIT_LOAD_OKAY     = 1;
	localparam int          BIT_RIE      = 0;
	localparam int          BIT_RFLAG    = 0;
	localparam int          PW_W         = 16;
	localparam int          CNT_W        = 15;
	localparam logic [15:0] PW_RESET     = 16'h0000;
	localparam logic [7:0]  ENC_RESET    = 8'h00;
endpackage : pwm_a_pkg

// >>> pwm_channel_out.sv
// Purpose: one pulse-width comparator driving a pwm pin
// Assumes: edge-aligned counter running 0..modulus-1
// Notes:   pin is registered
`timescale 1ns/10ps
`default_nettype none
module pwm_channel_out #(
	parameter int PW_W  = 16,
	parameter int CNT_W = 15
) (
	input  wire logic                    sys_clk_i,
	input  wire logic                    reset_i,
	input  wire logic                    enable_i,
	input  wire logic                    sw_ctl_i,
	input  wire logic                    sw_val_i,
	input  wire logic signed [PW_W-1:0]  value_i,
	input  wire logic        [CNT_W-1:0] modulus_i,
	input  wire logic        [CNT_W-1:0] count_i,
	output logic                         pin_o
);
	logic active;
	logic signed [PW_W:0] mod_s;
	logic signed [PW_W:0] cnt_s;
	logic signed [PW_W:0] val_s;

	always_comb
	begin
		mod_s = {{(PW_W+1-CNT_W){1'b0}}, modulus_i};
		cnt_s = {{(PW_W+1-CNT_W){1'b0}}, count_i};
		val_s = {value_i[PW_W-1], value_i};
		if (val_s <= 0)
			active = 1'b0; // [R02]
		else if (val_s >= mod_s)
			active = 1'b1; // [R03]
		else
			active = (cnt_s < val_s);
	end

	always_ff @(posedge sys_clk_i)
	begin
		if (reset_i)
			pin_o <= 1'b0;
		else if (sw_ctl_i)
			pin_o <= sw_val_i;
		else if (!enable_i)
			pin_o <= 1'b0;
		else
			pin_o <= active; // high = activated [R04]
	end
endmodule : pwm_channel_out
`default_nettype wire

// >>> pwm_power_stage.sv
// Purpose: power stage model on the channel 4/5 pins, totals switch on-time
// Assumes: push-pull pins, a high pin turns the upper switch on
// Notes:   totals restart while clr_i is high
`timescale 1ns/10ps
`default_nettype none
module pwm_power_stage (
	input  wire logic        sys_clk_i,
	input  wire logic        clr_i,
	input  wire logic        pwm4_i,
	input  wire logic        pwm5_i,
	output logic      [15:0] on4_o,
	output logic      [15:0] on5_o
);
	// an unknown pin counts as off, so a floating output never passes as a pulse
	always_ff @(posedge sys_clk_i)
	begin
		if (clr_i)
		begin
			on4_o <= 16'h0000;
			on5_o <= 16'h0000;
		end
		else
		begin
			on4_o <= on4_o + {15'h0000, pwm4_i === 1'b1};
			on5_o <= on5_o + {15'h0000, pwm5_i === 1'b1};
		end
	end
endmodule : pwm_power_stage
`default_nettype wire

// >>> pwm_gen_a_value_load_enable_tb_top.sv
// Purpose: self-checking bench for the generator A value/load/enable block
// Assumes: wishbone slave answers within a few cycles
// Notes:   pins judged by on-time over one full period of 20 counts
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; $display("mismatch at %0t: got %0h expected %0h", $time, a, b); end end
module pwm_gen_a_value_load_enable_tb_top;
	logic        clk, rst, cyc, stb, we, ack, mode, rl_a, rl_c, lok_c, en_c, clr;
	logic        ena, bc, lda, lok, irq, p4, p5, lda_seen;
	logic [31:0] adr, dat, rdat, q;
	logic [3:0]  sel;
	logic [5:4]  swc, swv;
	logic [14:0] mod, cnt;
	logic [15:0] pw4, pw5, on4, on5, w, v5;
	logic [15:0] tbl [8];
	int          err_total;
	int          compares;
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// period counter for ch4/5, counts 0..mod-1
	always_ff @(posedge clk)
		cnt <= (rst || cnt >= mod - 15'h0001) ? 15'h0000 : cnt + 15'h0001;
	pwm_gen_a_value_load_enable u_dut (.sys_clk_i(clk), .reset_i(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .multi_generator_mode_i(mode), .reload_a_i(rl_a),
		.reload_c_i(rl_c), .load_okay_c_i(lok_c), .gen_c_enable_i(en_c),
		.output_software_control_i(swc), .output_software_value_i(swv),
		.counter_modulus_c_i(mod), .count_c_i(cnt), .gen_a_enable_o(ena),
		.gen_bc_enable_o(bc), .load_a_o(lda), .load_okay_a_o(lok), .reload_irq_a_o(irq),
		.pulse_width_ch4_o(pw4), .pulse_width_ch5_o(pw5), .pwm4_o(p4), .pwm5_o(p5));
	pwm_power_stage u_stage (.sys_clk_i(clk), .clr_i(clr), .pwm4_i(p4), .pwm5_i(p5),
		.on4_o(on4), .on5_o(on5));
	function automatic logic [15:0] exp_on(input logic signed [15:0] v, input logic [14:0] m);
		if (v <= 0)
			return 16'h0000;
		if (v >= $signed({1'b0, m}))
			return {1'b0, m};
		return v;
	endfunction : exp_on
	task automatic summarize();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	// one classic cycle; q holds read data, then two idle cycles let flags settle
	task automatic bus(input logic [3:0] a, input logic wr, input logic [31:0] d);
		int n;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= wr;
		adr <= {28'h0000000, a};
		dat <= d;
		for (n = 0; n < 40 && ack !== 1'b1; n++)
			@(posedge clk);
		if (n == 40)
		begin
			err_total++;
			summarize();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
		repeat (2) @(posedge clk);
	endtask : bus
	// load-okay only sets after a read that saw it clear
	task automatic set_ctl(input logic [7:0] v);
		bus(4'h8, 1'b0, 32'h0);
		bus(4'h8, 1'b1, {24'h000000, v});
	endtask : set_ctl
	// the load pulse stands one cycle, so it is caught between edges
	task automatic reload(input logic c);
		@(posedge clk);
		rl_a <= ~c;
		rl_c <= c;
		@(posedge clk);
		rl_a <= 1'b0;
		rl_c <= 1'b0;
		#1;
		lda_seen = lda;
		repeat (2) @(posedge clk);
	endtask : reload
	task automatic duty(input logic [15:0] e4, input logic [15:0] e5);
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		repeat (21) @(posedge clk);
		`CHK(on4, e4)
		`CHK(on5, e5)
	endtask : duty
	initial
	begin
		{cyc, stb, we, rl_a, rl_c, lok_c, en_c, mode, clr} = '0;
		adr = '0;
		dat = '0;
		sel = 4'h3;
		swc = '0;
		swv = '0;
		mod = 15'h0014;
		rst = 1'b1;
		err_total = 0;
		compares = 0;
		q = $urandom(61);
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		bus(4'h8, 1'b0, 32'h0);
		`CHK(q[7:0], 8'h00)
		`CHK(lok, 1'b0)
		repeat (4)
		begin
			w = 16'($urandom);
			bus(4'h0, 1'b1, {16'h0000, w});
			bus(4'h4, 1'b1, {16'h0000, ~w});
			bus(4'h0, 1'b0, 32'h0);
			`CHK(q[15:0], w)
			bus(4'h4, 1'b0, 32'h0);
			`CHK(q[15:0], ~w)
			reload(1'b0);
			`CHK(pw4, 16'h0000)
			`CHK(lda_seen, 1'b0)
		end
		bus(4'h8, 1'b1, 32'h0);
		bus(4'h8, 1'b1, 32'h2);
		`CHK(lok, 1'b0)
		set_ctl(8'h02);
		`CHK(lok, 1'b1)
		bus(4'h8, 1'b1, 32'h82);
		`CHK(ena, 1'b1)
		`CHK(bc, 1'b1)
		reload(1'b0);
		`CHK(lda_seen, 1'b1)
		`CHK(pw4, w)
		`CHK(pw5, ~w)
		`CHK(lok, 1'b0)
		set_ctl(8'h82);
		bus(4'h8, 1'b1, 32'h80);
		`CHK(lok, 1'b0)
		bus(4'h0, 1'b1, 32'h1234);
		reload(1'b0);
		`CHK(pw4, w)
		bus(4'h8, 1'b1, 32'h81);
		`CHK(irq, 1'b1)
		bus(4'h8, 1'b1, 32'h80);
		`CHK(irq, 1'b0)
		bus(4'hc, 1'b0, 32'h0);
		`CHK(q[0], 1'b1)
		bus(4'hc, 1'b1, 32'h1);
		bus(4'hc, 1'b0, 32'h0);
		`CHK(q[0], 1'b0)
		reload(1'b0);
		bus(4'hc, 1'b0, 32'h0);
		reload(1'b0);
		bus(4'hc, 1'b1, 32'h1);
		bus(4'hc, 1'b0, 32'h0);
		`CHK(q[0], 1'b1)
		tbl = '{16'hfffb, 16'h0000, 16'h0001, 16'h0013, 16'h0014, 16'h0019, 16'h8000, 16'h7fff};
		foreach (tbl[i])
		begin
			w = tbl[i];
			// odd passes reuse the corner table so channel 5 also sees full-period widths
			v5 = (i % 2 == 1) ? tbl[7-i] : 16'($urandom_range(19, 1));
			bus(4'h0, 1'b1, {16'h0000, w});
			bus(4'h4, 1'b1, {16'h0000, v5});
			set_ctl(8'h82);
			reload(1'b0);
			duty(exp_on(w, mod), exp_on(v5, mod));
		end
		bus(4'h8, 1'b1, 32'h0);
		duty(16'h0000, 16'h0000);
		swc <= 2'b11;
		swv <= 2'b10;
		duty(16'h0000, 16'h0014);
		swc <= 2'b00;
		mode <= 1'b1;
		en_c <= 1'b1;
		set_ctl(8'h82);
		`CHK(bc, 1'b0)
		`CHK(ena, 1'b1)
		bus(4'h0, 1'b1, 32'h5);
		reload(1'b0);
		`CHK(pw4, 16'h7fff)
		lok_c <= 1'b1;
		reload(1'b1);
		`CHK(pw4, 16'h0005)
		lok_c <= 1'b0;
		duty(16'h0005, exp_on(v5, mod));
		set_ctl(8'h82);
		`CHK(lok, 1'b1)
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		bus(4'h8, 1'b0, 32'h0);
		`CHK(q[7:0], 8'h00)
		`CHK(lok, 1'b0)
		summarize();
	end
endmodule : pwm_gen_a_value_load_enable_tb_top
`default_nettype wire
